// ---- verilog/pis_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module pis_sequencer (
  input wire logic mclk,
  input wire logic rst_n,
  input wire pis_pkg::pis_mon_t mon,
  input wire logic enable_pin_cmp,
  input wire logic vin_cmp,
  input wire logic [pis_pkg::DW-1:0] nonvolatile_store_data,
  input wire pis_pkg::pis_strap_t strap,
  input wire pis_pkg::pis_cmd_t cmd,
  input wire logic [pis_pkg::NV_AW-1:0] cfg_rd_addr,
  output logic [pis_pkg::NV_AW-1:0] nonvolatile_store_addr,
  output logic nonvolatile_store_rd,
  output logic int_reset_n,
  output logic load_done,
  output logic addr_done,
  output logic digital_mode,
  output logic [pis_pkg::ADDR_W-1:0] i2c_addr,
  output logic [pis_pkg::ADDR_W-1:0] pmbus_addr,
  output logic i2c_active,
  output logic pmbus_active,
  output logic conv_enable,
  output logic [pis_pkg::DW-1:0] cfg_rd_data
);

  // ----------------------------------------------------------------
  // Monitor synchronisers
  // ----------------------------------------------------------------
  logic [2:0] mon_meta;
  logic [2:0] mon_sync;
  logic en_meta, en_sync, vin_meta, vin_sync;
  logic por_ok;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mon_meta <= 3'h0;
      mon_sync <= 3'h0;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      vin_meta <= 1'b0;
      vin_sync <= 1'b0;
    end else begin
      mon_meta <= mon;
      mon_sync <= mon_meta;
      en_meta <= enable_pin_cmp;
      en_sync <= en_meta;
      vin_meta <= vin_cmp;
      vin_sync <= vin_meta;
    end
  end

  assign por_ok = &mon_sync;

  // ----------------------------------------------------------------
  // Initialization sequence
  // ----------------------------------------------------------------
  pis_pkg::pis_state_t state;
  logic [pis_pkg::NV_AW-1:0] load_cnt;
  logic load_pend;
  logic [pis_pkg::NV_AW-1:0] load_wr_addr;
  logic [pis_pkg::OFFS_W-1:0] offset_q;
  logic [pis_pkg::DW-1:0] work_reg [pis_pkg::NV_WORDS];
  logic cmd_take;

  // A monitor drop restarts the whole sequence: the loaded image cannot be trusted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pis_pkg::PIS_RESET;
      load_cnt <= pis_pkg::REG_I2C_BASE;
      load_pend <= 1'b0;
      load_wr_addr <= pis_pkg::REG_I2C_BASE;
      load_done <= 1'b0;
      addr_done <= 1'b0;
      digital_mode <= 1'b0;
      offset_q <= pis_pkg::OFFS_RESET;
      int_reset_n <= 1'b0;
      nonvolatile_store_rd <= 1'b0;
    end else if (!por_ok) begin
      state <= pis_pkg::PIS_RESET;
      load_cnt <= pis_pkg::REG_I2C_BASE;
      load_pend <= 1'b0;
      load_done <= 1'b0;
      addr_done <= 1'b0;
      digital_mode <= 1'b0;
      int_reset_n <= 1'b0;
      nonvolatile_store_rd <= 1'b0;
    end else begin
      int_reset_n <= 1'b1;
      load_pend <= nonvolatile_store_rd;
      load_wr_addr <= load_cnt;
      unique case (state)
        pis_pkg::PIS_RESET: begin
          state <= pis_pkg::PIS_LOAD;
          load_cnt <= pis_pkg::REG_I2C_BASE;
          nonvolatile_store_rd <= 1'b1;
        end
        pis_pkg::PIS_LOAD: begin
          if (nonvolatile_store_rd) begin
            if (load_cnt == pis_pkg::LAST_WORD) begin
              nonvolatile_store_rd <= 1'b0;
            end else begin
              load_cnt <= load_cnt + 3'h1;
            end
          end else if (load_pend) begin
            load_done <= 1'b1;
            state <= pis_pkg::PIS_ADDR;
          end
        end
        pis_pkg::PIS_ADDR: begin
          if (strap.valid) begin
            digital_mode <= !strap.floating;
            offset_q <= strap.floating ? pis_pkg::OFFS_RESET : strap.offset;
            addr_done <= 1'b1;
            state <= pis_pkg::PIS_RUN;
          end
        end
        pis_pkg::PIS_RUN: begin
          state <= pis_pkg::PIS_RUN;
        end
      endcase
    end
  end

  assign nonvolatile_store_addr = load_cnt;

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  // writes after load and address read, in digital mode only
  assign cmd_take = cmd.valid && load_done && addr_done && digital_mode;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < pis_pkg::NV_WORDS; i++) begin
        work_reg[i] <= pis_pkg::WORK_RESET;
      end
    end else if (load_pend && !load_done) begin
      work_reg[load_wr_addr] <= nonvolatile_store_data;
    end else if (cmd_take) begin
      work_reg[cmd.addr] <= cmd.data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rd_data <= pis_pkg::WORK_RESET;
    end else begin
      cfg_rd_data <= work_reg[cfg_rd_addr];
    end
  end

  // ----------------------------------------------------------------
  // Bus addresses
  // ----------------------------------------------------------------
  logic [pis_pkg::ADDR_W-1:0] i2c_base, pmb_base;
  assign i2c_base = work_reg[pis_pkg::REG_I2C_BASE][pis_pkg::ADDR_W-1:0];
  assign pmb_base = work_reg[pis_pkg::REG_PMB_BASE][pis_pkg::ADDR_W-1:0];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_addr <= pis_pkg::ADDR_ZERO;
      pmbus_addr <= pis_pkg::ADDR_ZERO;
      i2c_active <= 1'b0;
      pmbus_active <= 1'b0;
    end else begin
      i2c_addr <= i2c_base + {3'h0, offset_q};
      pmbus_addr <= pmb_base + {3'h0, offset_q};
      i2c_active <= digital_mode && addr_done && (i2c_base != pis_pkg::ADDR_ZERO);
      pmbus_active <= digital_mode && addr_done && (pmb_base != pis_pkg::ADDR_ZERO);
    end
  end

  // ----------------------------------------------------------------
  // Conversion enable
  // ----------------------------------------------------------------
  logic sw_ovr, sw_on, init_ok;
  assign sw_ovr = digital_mode && work_reg[pis_pkg::REG_EN_OPT][pis_pkg::EN_OPT_OVR_BIT];
  assign sw_on = work_reg[pis_pkg::REG_EN_OPT][pis_pkg::EN_OPT_ON_BIT];
  assign init_ok = load_done && addr_done;

  // Input-bus comparator stays in force even under override, so a low
  // supply can never be switched on by software
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_enable <= 1'b0;
    end else begin
      conv_enable <= init_ok && vin_sync && (sw_ovr ? sw_on : en_sync);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_strap_taken;
    state == pis_pkg::PIS_ADDR && strap.valid && !strap.floating;
  endsequence

  sequence seq_load_start;
    state == pis_pkg::PIS_RESET && por_ok;
  endsequence

  AST_POR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !por_ok |=> state == pis_pkg::PIS_RESET && !int_reset_n && !load_done)
    else $error("sequencer left reset with a monitor low");

  AST_LOAD_START: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_load_start |=> state == pis_pkg::PIS_LOAD && nonvolatile_store_rd
      && load_cnt == pis_pkg::REG_I2C_BASE)
    else $error("load cycle did not start after reset release");

  AST_CMD_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_take |=> work_reg[$past(cmd.addr)] == $past(cmd.data))
    else $error("accepted bus write not stored");

  AST_CONV_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    conv_enable |-> $past(init_ok) && $past(vin_sync))
    else $error("conversion enabled before init or input bus good");

  AST_PIN_OVERRIDE: assert property (@(posedge mclk) disable iff (!rst_n)
    init_ok && vin_sync && sw_ovr && sw_on && !en_sync && por_ok |=> conv_enable)
    else $error("software override did not enable conversion");

  AST_ZERO_ADDR: assert property (@(posedge mclk) disable iff (!rst_n)
    i2c_active |-> $past(i2c_base) != pis_pkg::ADDR_ZERO && $past(digital_mode))
    else $error("i2c active with zero base or analog mode");

  AST_ANALOG_LOCK: assert property (@(posedge mclk) disable iff (!rst_n)
    addr_done && !digital_mode && por_ok && cmd.valid |=>
      work_reg[$past(cmd.addr)] == $past(work_reg[cmd.addr]))
    else $error("working register changed in analog mode");

  AST_OFFSET_ADD: assert property (@(posedge mclk) disable iff (!rst_n)
    seq_strap_taken ##1 (por_ok && !cmd_take) |=>
      pmbus_addr == $past(pmb_base) + {3'h0, $past(strap.offset, 2)})
    else $error("pmbus address not base plus strap offset");

  AST_STEP_ORDER: assert property (@(posedge mclk) disable iff (!rst_n)
    addr_done |-> load_done && int_reset_n)
    else $error("address read finished before load");

endmodule : pis_sequencer
`default_nettype wire

// ---- shared/pis_pkg.sv ----
package pis_pkg;

  // ----------------------------------------------------------------
  // Working register file geometry and layout
  // ----------------------------------------------------------------
  localparam int NV_WORDS = 8;
  localparam int NV_AW = 3;
  localparam int DW = 8;
  localparam int ADDR_W = 7;
  localparam int OFFS_W = 4;
  localparam logic [NV_AW-1:0] REG_I2C_BASE = 3'h0;
  localparam logic [NV_AW-1:0] REG_PMB_BASE = 3'h1;
  localparam logic [NV_AW-1:0] REG_EN_OPT = 3'h2;
  localparam logic [NV_AW-1:0] LAST_WORD = 3'h7;
  localparam int EN_OPT_OVR_BIT = 0;
  localparam int EN_OPT_ON_BIT = 1;
  localparam logic [DW-1:0] WORK_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;
  localparam logic [OFFS_W-1:0] OFFS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int SYNC_STAGES = 2;

  typedef enum {
    PIS_RESET,
    PIS_LOAD,
    PIS_ADDR,
    PIS_RUN
  } pis_state_t;

  typedef struct packed {
    logic bias_ok;
    logic core_rail_ok;
    logic osc_stable;
  } pis_mon_t;

  typedef struct packed {
    logic valid;
    logic floating;
    logic [OFFS_W-1:0] offset;
  } pis_strap_t;

  typedef struct packed {
    logic valid;
    logic [NV_AW-1:0] addr;
    logic [DW-1:0] data;
  } pis_cmd_t;

endpackage : pis_pkg

// ---- test/pis_nv_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module pis_nv_model (
  input wire logic mclk,
  input wire logic blank_i2c_base,
  input wire logic [pis_pkg::NV_AW-1:0] addr,
  input wire logic rd,
  output logic [pis_pkg::DW-1:0] data
);
  // ----------------------------------------------------------------
  // Store image: I2C base, PMBus base, enable options, general words
  // ----------------------------------------------------------------
  logic [pis_pkg::DW-1:0] mem [pis_pkg::NV_WORDS];
  logic [pis_pkg::DW-1:0] word;

  initial begin
    mem = '{8'h10, 8'h40, 8'h00, 8'ha5, 8'h3c, 8'h96, 8'h0f, 8'hf0};
  end

  // Zero I2C base image without touching the stored array
  assign word = (blank_i2c_base && addr == pis_pkg::REG_I2C_BASE) ? 8'h00 : mem[addr];

  // word per read
  // Outside a burst the bus shows the inverse so a stale word is never mistaken for data
  always_ff @(posedge mclk) begin
    if (rd) begin
      data <= word;
    end else begin
      data <= ~word;
    end
  end
endmodule : pis_nv_model
`default_nettype wire

// ---- test/powerup_init_sequencer_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module powerup_init_sequencer_tb;
  logic mclk, rst_n, en_pin, vin, nv_rd, int_rst_n, load_done, addr_done, dig;
  logic i2c_act, pmb_act, conv, blank_base;
  pis_pkg::pis_mon_t mon;
  pis_pkg::pis_strap_t strap;
  pis_pkg::pis_cmd_t cmd;
  logic [pis_pkg::NV_AW-1:0] rd_addr, nv_addr;
  logic [pis_pkg::DW-1:0] nv_data, rd_data;
  logic [pis_pkg::ADDR_W-1:0] i2c_addr, pmb_addr;
  int error_cnt = 0;
  int samples_checked = 0;

  pis_sequencer i_pis_sequencer (.mclk(mclk), .rst_n(rst_n), .mon(mon),
    .enable_pin_cmp(en_pin), .vin_cmp(vin), .nonvolatile_store_data(nv_data),
    .strap(strap), .cmd(cmd), .cfg_rd_addr(rd_addr), .nonvolatile_store_addr(nv_addr),
    .nonvolatile_store_rd(nv_rd), .int_reset_n(int_rst_n), .load_done(load_done),
    .addr_done(addr_done), .digital_mode(dig), .i2c_addr(i2c_addr),
    .pmbus_addr(pmb_addr), .i2c_active(i2c_act), .pmbus_active(pmb_act),
    .conv_enable(conv), .cfg_rd_data(rd_data));

  pis_nv_model i_pis_nv_model (.mclk(mclk), .blank_i2c_base(blank_base), .addr(nv_addr),
    .rd(nv_rd), .data(nv_data));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_bit(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask : chk_bit

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : cyc

  // Monitors drop then return, so every call restarts the whole sequence
  task automatic bring_up(input logic [3:0] offs, input logic flt);
    mon = 3'b000;
    cyc(4);
    mon = 3'b111;
    for (int i = 0; i < 60 && load_done !== 1'b1; i++) cyc(1);
    chk_bit("load_done", 1'b1, load_done);
    chk_bit("addr_done early", 1'b0, addr_done);
    chk_bit("conv early", 1'b0, conv);
    strap = '{valid: 1'b1, floating: flt, offset: offs};
    cyc(1);
    strap.valid = 1'b0;
    cyc(4);
    chk_bit("addr_done", 1'b1, addr_done);
  endtask : bring_up

  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    cmd = '{valid: 1'b1, addr: a, data: d};
    cyc(1);
    cmd.valid = 1'b0;
  endtask : write_reg

  task automatic read_chk(input logic [2:0] a, input logic [7:0] exp);
    rd_addr = a;
    cyc(2);
    chk("cfg_rd_data", exp, rd_data);
  endtask : read_chk

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por;
    for (int i = 0; i < 3; i++) begin
      mon = 3'b111 ^ (3'b001 << i);
      cyc(8);
      chk_bit("int_reset_n", 1'b0, int_rst_n);
      chk_bit("nv read", 1'b0, nv_rd);
    end
  endtask : t_por

  task automatic t_load_digital;
    bring_up(4'hf, 1'b0);
    chk_bit("int_reset_n", 1'b1, int_rst_n);
    for (int i = 0; i < 8; i++) read_chk(i[2:0], i_pis_nv_model.mem[i]);
    chk("i2c_addr", 8'h1f, {1'b0, i2c_addr});
    chk("pmbus_addr", 8'h4f, {1'b0, pmb_addr});
    chk_bit("digital", 1'b1, dig);
    chk_bit("i2c_active", 1'b1, i2c_act);
    chk_bit("pmbus_active", 1'b1, pmb_act);
  endtask : t_load_digital

  task automatic t_conv;
    for (int i = 0; i < 4; i++) begin
      {en_pin, vin} = i[1:0];
      cyc(5);
      chk_bit("conv pin", i == 3, conv);
    end
    en_pin = 1'b0;
    write_reg(3'h2, 8'h03);
    cyc(5);
    chk_bit("conv sw on", 1'b1, conv);
    read_chk(3'h2, 8'h03);
    write_reg(3'h2, 8'h01);
    en_pin = 1'b1;
    cyc(5);
    chk_bit("conv sw off", 1'b0, conv);
    write_reg(3'h2, 8'h00);
  endtask : t_conv

  task automatic t_zero_base;
    blank_base = 1'b1;
    bring_up(4'h0, 1'b0);
    chk_bit("i2c_active zero", 1'b0, i2c_act);
    chk_bit("pmbus_active on", 1'b1, pmb_act);
    chk("pmbus_addr", 8'h40, {1'b0, pmb_addr});
    blank_base = 1'b0;
  endtask : t_zero_base

  task automatic t_analog;
    bring_up(4'h5, 1'b1);
    chk_bit("digital", 1'b0, dig);
    chk_bit("i2c_active", 1'b0, i2c_act);
    chk_bit("pmbus_active", 1'b0, pmb_act);
    chk("i2c_addr analog", 8'h10, {1'b0, i2c_addr});
    write_reg(3'h3, 8'h5a);
    read_chk(3'h3, 8'ha5);
  endtask : t_analog

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Whole run is about 150 cycles; the 20000-cycle limit leaves wide margin
  initial begin
    #(50 * 20000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    mon = 3'b000;
    en_pin = 1'b0;
    vin = 1'b0;
    blank_base = 1'b0;
    strap = '0;
    cmd = '0;
    rd_addr = 3'h0;
    cyc(10);
    rst_n = 1'b1;
    t_por();
    t_load_digital();
    t_conv();
    t_zero_base();
    t_analog();
    wrap_up();
  end
endmodule : powerup_init_sequencer_tb
`default_nettype wire
